/* mae_unit.sv */
/*
  Address extension unit: turns 16-bit virtual addresses of fetch, data
  and DMA accesses into 22-bit physical addresses and holds the paging
  and segment registers.
  Assumes the core gives register accesses as one-cycle strobes with an
  8-bit register number and current page, and requests one translation
  per cycle; results appear one cycle later from flip-flops.
*/
// Notes on behaviour
// - Extend 16-bit virtual to 22-bit physical
// - 64 segments of four 16K pages
// - Data: offset 13:0, page register above
// - Virtual bits 15:14 pick page register
// - Paging only when no DMA runs
// - Segment mode: six-bit segment above 16
// - Fetch and DMA use segment mode
// - Code segment for fetch and program data
// - Segment jump, call, return load code segment
// - Code segment resets to zero
// - Segment registers keep six bits only
// - Interrupt fetch uses interrupt segment
// - DMA choice bit picks DMA or interrupt segment
// - Relocate bit moves page registers to E0
// - Save bit clear: irq code via interrupt segment
// - Save bit set: stack and load code segment
`include "mae_regs.svh"
`timescale 1ns/1ps
`default_nettype none
module mae_unit (
  input wire logic mclk,
  input wire logic nrst,
  // Register access from the core
  input wire logic reg_wr,
  input wire logic reg_rd,
  input wire logic [7:0] reg_num,
  input wire logic [5:0] reg_page,
  input wire logic [7:0] reg_wdata,
  output logic [7:0] reg_rdata,
  output logic reg_hit,
  // Translation request
  input wire logic req_valid,
  input wire mae_pkg::mae_req_t req_kind,
  input wire logic [15:0] req_vaddr,
  input wire logic req_prog_data,
  input wire logic in_irq,
  input wire logic dma_segment_choice,
  // Code segment updates from the sequencer
  input wire logic seg_load,
  input wire logic [5:0] seg_load_val,
  input wire logic irq_enter,
  input wire logic irq_return,
  input wire logic [5:0] irq_pop_val,
  output logic [5:0] irq_push_val,
  output logic irq_push,
  // Translated address
  output logic phys_valid,
  output logic [21:0] phys_addr
);

  // Synchronised reset copy
  logic rst_meta_reg;
  logic rst_n_reg;

  // Reset release, two flops
  always_ff @(posedge mclk or negedge nrst) begin
    if (!nrst) begin
      rst_meta_reg <= 1'b0;
      rst_n_reg <= 1'b0;
    end else begin
      rst_meta_reg <= 1'b1;
      rst_n_reg <= rst_meta_reg;
    end
  end

  // Page registers, undefined at reset in the part; zero here for safety
  logic [7:0] dps_reg [4];
  logic [7:0] dps_next [4];
  logic [5:0] css_reg, css_next;
  logic [5:0] iss_reg, iss_next;
  logic [5:0] tss_reg, tss_next;
  // Mode bits of extended mode register 2
  logic page_reg_relocate_reg, page_reg_relocate_next;
  logic save_code_seg_on_irq_reg, save_code_seg_on_irq_next;
  logic [7:0] extended_mode_reg_2_other_reg, extended_mode_reg_2_other_next;
  // Register port answer
  logic [7:0] rdata_reg, rdata_next;
  logic hit_reg, hit_next;
  // Irq stacking outputs
  logic push_reg, push_next;
  logic [5:0] push_val_reg, push_val_next;
  // Translation outputs
  logic pv_reg, pv_next;
  logic [21:0] pa_reg, pa_next;
  mae_pkg::mae_state_t st_reg, st_next;

  // Decoded register index: 0-3 page, 4 code, 5 irq, 6 dma, 7 extended_mode_reg_2, 8 none
  function automatic logic [3:0] decode(input logic [7:0] num, input logic [5:0] pg,
                                        input logic reloc);
    logic [3:0] r;
    r = 4'h8;
    if (reloc && num[7:2] == 6'(`MAE_RELOC_BASE >> 2))
      r = {2'b00, num[1:0]};
    else if (pg == `MAE_PAGE_MAP) begin
      case (num)
        `MAE_DPS0_OFF, `MAE_DPS1_OFF, `MAE_DPS2_OFF, `MAE_DPS3_OFF:
          r = reloc ? 4'h8 : {2'b00, num[1:0]};
        `MAE_CSS_OFF: r = 4'h4;
        `MAE_ISS_OFF: r = 4'h5;
        `MAE_TSS_OFF: r = 4'h6;
        `MAE_EXTENDED_MODE_REG_2_OFF: r = 4'h7;
        default: r = 4'h8;
      endcase
    end
    return r;
  endfunction

  // Register file next values
  always_comb begin
    logic [3:0] idx;
    idx = decode(reg_num, reg_page, page_reg_relocate_reg);
    for (int i = 0; i < 4; i++) dps_next[i] = dps_reg[i];
    css_next = css_reg;
    iss_next = iss_reg;
    tss_next = tss_reg;
    page_reg_relocate_next = page_reg_relocate_reg;
    save_code_seg_on_irq_next = save_code_seg_on_irq_reg;
    extended_mode_reg_2_other_next = extended_mode_reg_2_other_reg;
    rdata_next = rdata_reg;
    hit_next = 1'b0;
    push_next = 1'b0;
    push_val_next = push_val_reg;
    st_next = st_reg;
    if (reg_wr && idx != 4'h8) begin
      case (idx)
        4'h4: css_next = reg_wdata[5:0];
        4'h5: iss_next = reg_wdata[5:0];
        4'h6: tss_next = reg_wdata[5:0];
        4'h7: begin
          extended_mode_reg_2_other_next = reg_wdata;
          page_reg_relocate_next = reg_wdata[`MAE_EXTENDED_MODE_REG_2_RELOC_BIT];
          save_code_seg_on_irq_next = reg_wdata[`MAE_EXTENDED_MODE_REG_2_SAVE_BIT];
        end
        default: dps_next[idx[1:0]] = reg_wdata;
      endcase
    end
    if (reg_rd || reg_wr)
      hit_next = (idx != 4'h8);
    if (reg_rd) begin
      case (idx)
        4'h4: rdata_next = {2'b00, css_reg};
        4'h5: rdata_next = {2'b00, iss_reg};
        4'h6: rdata_next = {2'b00, tss_reg};
        4'h7: rdata_next = extended_mode_reg_2_other_reg;
        4'h8: rdata_next = 8'h00;
        default: rdata_next = dps_reg[idx[1:0]];
      endcase
    end
    if (seg_load)
      css_next = seg_load_val;
    case (st_reg)
      mae_pkg::MAE_IDLE: begin
        if (irq_enter) begin
          st_next = mae_pkg::MAE_IN_IRQ;
          if (save_code_seg_on_irq_reg) begin
            push_next = 1'b1;
            push_val_next = css_reg;
            css_next = iss_reg;
          end
        end
      end
      mae_pkg::MAE_IN_IRQ: begin
        if (irq_return) begin
          st_next = mae_pkg::MAE_IDLE;
          if (save_code_seg_on_irq_reg)
            css_next = irq_pop_val;
        end
      end
      default: st_next = mae_pkg::MAE_IDLE;
    endcase
  end

  // Register file flops
  always_ff @(posedge mclk or negedge rst_n_reg) begin
    if (!rst_n_reg) begin
      for (int i = 0; i < 4; i++) dps_reg[i] <= 8'h00;
      css_reg <= `MAE_CSS_RESET;
      iss_reg <= 6'h00;
      tss_reg <= 6'h00;
      page_reg_relocate_reg <= 1'b0;
      save_code_seg_on_irq_reg <= 1'b0;
      extended_mode_reg_2_other_reg <= 8'h00;
      rdata_reg <= 8'h00;
      hit_reg <= 1'b0;
      push_reg <= 1'b0;
      push_val_reg <= 6'h00;
      st_reg <= mae_pkg::MAE_IDLE;
    end else begin
      for (int i = 0; i < 4; i++) dps_reg[i] <= dps_next[i];
      css_reg <= css_next;
      iss_reg <= iss_next;
      tss_reg <= tss_next;
      page_reg_relocate_reg <= page_reg_relocate_next;
      save_code_seg_on_irq_reg <= save_code_seg_on_irq_next;
      extended_mode_reg_2_other_reg <= extended_mode_reg_2_other_next;
      rdata_reg <= rdata_next;
      hit_reg <= hit_next;
      push_reg <= push_next;
      push_val_reg <= push_val_next;
      st_reg <= st_next;
    end
  end

  always_comb begin
    logic [5:0] seg;
    seg = css_reg;
    pv_next = req_valid;
    pa_next = pa_reg;
    if (req_valid) begin
      case (req_kind)
        mae_pkg::MAE_REQ_DMA: begin
          seg = dma_segment_choice ? tss_reg : iss_reg;
          pa_next = {seg, req_vaddr};
        end
        mae_pkg::MAE_REQ_FETCH: begin
          // irq code via interrupt segment when not saving
          seg = (in_irq && !save_code_seg_on_irq_reg) ? iss_reg : css_reg;
          pa_next = {seg, req_vaddr};
        end
        default: begin
          if (req_prog_data)
            pa_next = {css_reg, req_vaddr};
          else
            pa_next = {dps_reg[req_vaddr[15:14]], req_vaddr[13:0]};
        end
      endcase
    end
  end

  always_ff @(posedge mclk or negedge rst_n_reg) begin
    if (!rst_n_reg) begin
      pv_reg <= 1'b0;
      pa_reg <= 22'h000000;
    end else begin
      pv_reg <= pv_next;
      pa_reg <= pa_next;
    end
  end

  assign reg_rdata = rdata_reg;
  assign reg_hit = hit_reg;
  assign irq_push = push_reg;
  assign irq_push_val = push_val_reg;
  assign phys_valid = pv_reg;
  assign phys_addr = pa_reg;

  property p_page_pick;
    @(posedge mclk) disable iff (!rst_n_reg)
      (req_valid && req_kind == mae_pkg::MAE_REQ_DATA && !req_prog_data)
      |=> phys_addr == {$past(dps_reg[req_vaddr[15:14]]), $past(req_vaddr[13:0])};
  endproperty
  a_page_pick: assert property (p_page_pick) else $error("page translation wrong");

  property p_dma_seg;
    @(posedge mclk) disable iff (!rst_n_reg)
      (req_valid && req_kind == mae_pkg::MAE_REQ_DMA && dma_segment_choice)
      |=> phys_addr[21:16] == $past(tss_reg) && phys_addr[15:0] == $past(req_vaddr);
  endproperty
  a_dma_seg: assert property (p_dma_seg) else $error("dma segment wrong");

  property p_dma_iss;
    @(posedge mclk) disable iff (!rst_n_reg)
      (req_valid && req_kind == mae_pkg::MAE_REQ_DMA && !dma_segment_choice)
      |=> phys_addr[21:16] == $past(iss_reg) && phys_addr[15:0] == $past(req_vaddr);
  endproperty
  a_dma_iss: assert property (p_dma_iss) else $error("dma irq segment wrong");

  property p_fetch;
    @(posedge mclk) disable iff (!rst_n_reg)
      (req_valid && req_kind == mae_pkg::MAE_REQ_FETCH && !in_irq)
      |=> phys_addr == {$past(css_reg), $past(req_vaddr)};
  endproperty
  a_fetch: assert property (p_fetch) else $error("fetch segment wrong");

  property p_irq_fetch;
    @(posedge mclk) disable iff (!rst_n_reg)
      (req_valid && req_kind == mae_pkg::MAE_REQ_FETCH && in_irq && !save_code_seg_on_irq_reg)
      |=> phys_addr[21:16] == $past(iss_reg);
  endproperty
  a_irq_fetch: assert property (p_irq_fetch) else $error("irq fetch segment wrong");

  property p_save;
    @(posedge mclk) disable iff (!rst_n_reg)
      (st_reg == mae_pkg::MAE_IDLE && irq_enter && save_code_seg_on_irq_reg && !seg_load)
      |=> irq_push && irq_push_val == $past(css_reg) && css_reg == $past(iss_reg);
  endproperty
  a_save: assert property (p_save) else $error("code segment not stacked");

  property p_rsv;
    @(posedge mclk) disable iff (!rst_n_reg)
      reg_rd && reg_num == `MAE_CSS_OFF && reg_page == `MAE_PAGE_MAP
      |=> reg_rdata[7:6] == 2'b00 && reg_hit;
  endproperty
  a_rsv: assert property (p_rsv) else $error("reserved bits not zero");

  property p_load;
    @(posedge mclk) disable iff (!rst_n_reg)
      seg_load && !irq_enter && !irq_return |=> css_reg == $past(seg_load_val);
  endproperty
  a_load: assert property (p_load) else $error("segment load lost");

  c_dma: cover property (@(posedge mclk) req_valid && req_kind == mae_pkg::MAE_REQ_DMA);
  c_irq: cover property (@(posedge mclk) irq_push);
  c_reloc: cover property (@(posedge mclk) page_reg_relocate_reg && reg_hit);

endmodule
`default_nettype wire

/* mae_regs.svh */
/*
  Register offsets, field positions and reset values of the address
  extension unit. Assumes the core register file decodes page 21 and
  group E and hands this block an 8-bit register number.
*/
`ifndef MAE_REGS_SVH
`define MAE_REGS_SVH
`define MAE_DPS0_OFF 8'hF0
`define MAE_DPS1_OFF 8'hF1
`define MAE_DPS2_OFF 8'hF2
`define MAE_DPS3_OFF 8'hF3
`define MAE_CSS_OFF 8'hF4
`define MAE_ISS_OFF 8'hF8
`define MAE_TSS_OFF 8'hF9
`define MAE_EXTENDED_MODE_REG_2_OFF 8'hF6
`define MAE_RELOC_BASE 8'hE0
`define MAE_PAGE_MAP 6'h15
`define MAE_EXTENDED_MODE_REG_2_RELOC_BIT 5
`define MAE_EXTENDED_MODE_REG_2_SAVE_BIT 6
`define MAE_CSS_RESET 6'h00
`define MAE_SEG_W 6
`define MAE_PAGE_W 8
`endif

/* mae_pkg.sv */
/*
  Types of the address extension unit. Assumes nothing of its users.
*/
package mae_pkg;
  // Which kind of access asks for a physical address
  typedef enum logic [1:0] {
    MAE_REQ_DATA,
    MAE_REQ_FETCH,
    MAE_REQ_DMA
  } mae_req_t;
  // Irq stacking progress of the code segment
  typedef enum {
    MAE_IDLE,
    MAE_IN_IRQ
  } mae_state_t;
endpackage

/* mae_core_model.sv */
/*
  Core-side model of the address extension unit: fetch, data and DMA
  requester plus the interrupt sequencer with its code segment stack.
  Assumes its tasks are called one at a time, after reset release.
*/
`timescale 1ns/1ps
`default_nettype none
module mae_core_model (
  input wire logic mclk,
  input wire logic irq_push,
  input wire logic [5:0] irq_push_val,
  input wire logic phys_valid,
  input wire logic [21:0] phys_addr,
  output var mae_pkg::mae_req_t req_kind,
  output logic req_valid,
  output logic [15:0] req_vaddr,
  output logic req_prog_data,
  output logic in_irq,
  output logic dma_segment_choice,
  output logic seg_load,
  output logic [5:0] seg_load_val,
  output logic irq_enter,
  output logic irq_return,
  output logic [5:0] irq_pop_val
);
  // System stack slots for the code segment
  logic [5:0] stack_q[$];

  // Quiet idle levels at time zero
  initial begin
    req_kind = mae_pkg::MAE_REQ_DATA;
    {req_valid, req_prog_data, in_irq, dma_segment_choice} = 4'h0;
    {seg_load, irq_enter, irq_return} = 3'h0;
    req_vaddr = 16'h0000;
    seg_load_val = 6'h00;
    irq_pop_val = 6'h00;
  end

  // Stack takes the pushed segment
  always @(posedge mclk) begin
    if (irq_push === 1'b1) begin
      stack_q.push_back(irq_push_val);
    end
  end

  // pages are never rewritten through themselves
  task automatic xlat(input mae_pkg::mae_req_t k, input logic [15:0] va,
                      input logic pd, input logic irq, input logic ch,
                      output logic pv, output logic [21:0] pa);
    @(posedge mclk);
    req_valid <= 1'b1;
    req_kind <= k;
    req_vaddr <= va;
    req_prog_data <= pd;
    in_irq <= irq;
    dma_segment_choice <= ch;
    @(posedge mclk);
    req_valid <= 1'b0;
    // Released bus shows the inverse, not a stale copy
    req_vaddr <= ~va;
    #1;
    pv = phys_valid;
    pa = phys_addr;
  endtask

  // Segment jump or call
  task automatic load_seg(input logic [5:0] v);
    @(posedge mclk);
    seg_load <= 1'b1;
    seg_load_val <= v;
    @(posedge mclk);
    seg_load <= 1'b0;
    seg_load_val <= ~v;
  endtask

  // Interrupt entry; push pulse lands one cycle on
  task automatic irq_in(output logic p, output logic [5:0] v);
    @(posedge mclk);
    irq_enter <= 1'b1;
    @(posedge mclk);
    irq_enter <= 1'b0;
    #1;
    p = irq_push;
    v = irq_push_val;
  endtask

  // Interrupt return pops the saved segment
  task automatic irq_out();
    @(posedge mclk);
    irq_return <= 1'b1;
    irq_pop_val <= stack_q.pop_back();
    @(posedge mclk);
    irq_return <= 1'b0;
    irq_pop_val <= ~irq_pop_val;
  endtask
endmodule
`default_nettype wire

/* mmu_address_extension_tb.sv */
/*
  Testbench of the address extension unit: registers through the core
  register port, translations through the core model.
  Assumes answers come exactly one cycle after each strobe.
*/
`include "mae_regs.svh"
`timescale 1ns/1ps
`default_nettype none
module mmu_address_extension_tb;
  logic mclk;
  logic nrst;
  logic reg_wr;
  logic reg_rd;
  logic [7:0] reg_num;
  logic [5:0] reg_page;
  logic [7:0] reg_wdata;
  logic [7:0] reg_rdata;
  logic reg_hit;
  mae_pkg::mae_req_t req_kind;
  logic req_valid, req_prog_data, in_irq, dma_segment_choice;
  logic [15:0] req_vaddr;
  logic seg_load, irq_enter, irq_return, irq_push, phys_valid;
  logic [5:0] seg_load_val, irq_pop_val, irq_push_val;
  logic [21:0] phys_addr;
  int num_errors = 0;
  int checked = 0;
  int cycles = 0;

  mae_unit dut (.mclk(mclk), .nrst(nrst), .reg_wr(reg_wr), .reg_rd(reg_rd),
    .reg_num(reg_num), .reg_page(reg_page), .reg_wdata(reg_wdata),
    .reg_rdata(reg_rdata), .reg_hit(reg_hit), .req_valid(req_valid),
    .req_kind(req_kind), .req_vaddr(req_vaddr), .req_prog_data(req_prog_data),
    .in_irq(in_irq), .dma_segment_choice(dma_segment_choice),
    .seg_load(seg_load), .seg_load_val(seg_load_val), .irq_enter(irq_enter),
    .irq_return(irq_return), .irq_pop_val(irq_pop_val),
    .irq_push_val(irq_push_val), .irq_push(irq_push),
    .phys_valid(phys_valid), .phys_addr(phys_addr));

  mae_core_model core (.mclk(mclk), .irq_push(irq_push),
    .irq_push_val(irq_push_val), .phys_valid(phys_valid),
    .phys_addr(phys_addr), .req_kind(req_kind), .req_valid(req_valid),
    .req_vaddr(req_vaddr), .req_prog_data(req_prog_data), .in_irq(in_irq),
    .dma_segment_choice(dma_segment_choice), .seg_load(seg_load),
    .seg_load_val(seg_load_val), .irq_enter(irq_enter),
    .irq_return(irq_return), .irq_pop_val(irq_pop_val));

  // 200 MHz core clock
  initial begin
    mclk = 1'b0;
    forever #2.5 mclk = ~mclk;
  end

  // Hang guard, well above the roughly 110 cycles used
  always @(posedge mclk) begin
    cycles++;
    if (cycles == 5000) begin
      num_errors++;
      stop_test();
    end
  end

  task automatic chk(input string what, input logic [21:0] seen, input logic [21:0] exp);
    checked++;
    if (seen !== exp) begin
      num_errors++;
      $display("mismatch %s expected %h seen %h", what, exp, seen);
    end
  endtask

  // One-cycle register strobe, read data the cycle after
  task automatic acc(input logic w, input logic [7:0] n, input logic [5:0] p,
                     input logic [7:0] d, output logic [7:0] q, output logic h);
    @(posedge mclk);
    reg_wr <= w;
    reg_rd <= ~w;
    reg_num <= n;
    reg_page <= p;
    reg_wdata <= d;
    @(posedge mclk);
    reg_wr <= 1'b0;
    reg_rd <= 1'b0;
    // Released bus shows the inverse, not a stale copy
    reg_num <= ~n;
    reg_wdata <= ~d;
    #1;
    q = reg_rdata;
    h = reg_hit;
  endtask

  // Translation with its expected physical address
  task automatic tx(input mae_pkg::mae_req_t k, input logic [15:0] va,
                    input logic [2:0] m, input logic [21:0] exp);
    logic pv;
    logic [21:0] pa;
    core.xlat(k, va, m[2], m[1], m[0], pv, pa);
    chk("phys_valid", 22'(pv), 22'h1);
    chk("phys_addr", pa, exp);
  endtask

  task automatic stop_test();
    $display("checks %0d mismatches %0d", checked, num_errors);
    if (num_errors == 0 && checked > 0) begin
      $display("ALL CHECKS OK");
    end else begin
      $display("CHECKS NOT OK");
    end
    $finish;
  endtask

  initial begin
    logic [7:0] q;
    logic h;
    logic [5:0] v;
    {reg_wr, reg_rd, reg_num, reg_page, reg_wdata} = 24'h0;
    nrst = 1'b0;
    repeat (12) @(posedge mclk);
    nrst <= 1'b1;
    repeat (3) @(posedge mclk);
    acc(1'b0, `MAE_CSS_OFF, `MAE_PAGE_MAP, 8'h00, q, h);
    chk("css_reset", 22'(q), 22'h0);
    for (int i = 0; i < 4; i++) begin
      acc(1'b1, 8'(`MAE_DPS0_OFF + i), `MAE_PAGE_MAP, 8'(8'h81 + 8'h11 * i), q, h);
      acc(1'b0, 8'(`MAE_DPS0_OFF + i), `MAE_PAGE_MAP, 8'h00, q, h);
      chk("page_rd", 22'(q), 22'(8'h81 + 8'h11 * i));
    end
    // Both ends of every 16K window
    for (int j = 0; j < 8; j++) begin
      tx(mae_pkg::MAE_REQ_DATA, {2'(j >> 1), j[0] ? 14'h3FFF : 14'h0000}, 3'h0,
         {8'(8'h81 + 8'h11 * (j >> 1)), j[0] ? 14'h3FFF : 14'h0000});
    end
    // Reserved top bits written as ones
    acc(1'b1, `MAE_CSS_OFF, `MAE_PAGE_MAP, 8'hC5, q, h);
    acc(1'b1, `MAE_ISS_OFF, `MAE_PAGE_MAP, 8'hEA, q, h);
    acc(1'b1, `MAE_TSS_OFF, `MAE_PAGE_MAP, 8'hD5, q, h);
    acc(1'b0, `MAE_ISS_OFF, `MAE_PAGE_MAP, 8'h00, q, h);
    chk("iss_rd", 22'(q), 22'h2A);
    acc(1'b0, `MAE_TSS_OFF, `MAE_PAGE_MAP, 8'h00, q, h);
    chk("tss_rd", 22'(q), 22'h15);
    tx(mae_pkg::MAE_REQ_FETCH, 16'h1234, 3'h0, {6'h05, 16'h1234});
    tx(mae_pkg::MAE_REQ_DATA, 16'hC001, 3'h4, {6'h05, 16'hC001});
    tx(mae_pkg::MAE_REQ_DMA, 16'hC001, 3'h1, {6'h15, 16'hC001});
    tx(mae_pkg::MAE_REQ_DMA, 16'h8002, 3'h0, {6'h2A, 16'h8002});
    tx(mae_pkg::MAE_REQ_FETCH, 16'hFFFF, 3'h2, {6'h2A, 16'hFFFF});
    core.load_seg(6'h11);
    tx(mae_pkg::MAE_REQ_FETCH, 16'h0000, 3'h0, {6'h11, 16'h0000});
    // Save mode: old code segment stacked
    acc(1'b1, `MAE_EXTENDED_MODE_REG_2_OFF, `MAE_PAGE_MAP, 8'h40, q, h);
    core.irq_in(h, v);
    chk("push", 22'(h), 22'h1);
    chk("push_val", 22'(v), 22'h11);
    tx(mae_pkg::MAE_REQ_FETCH, 16'h0100, 3'h2, {6'h2A, 16'h0100});
    core.irq_out();
    tx(mae_pkg::MAE_REQ_FETCH, 16'h0200, 3'h0, {6'h11, 16'h0200});
    // Relocated pages, port window left unmapped
    acc(1'b1, `MAE_EXTENDED_MODE_REG_2_OFF, `MAE_PAGE_MAP, 8'h20, q, h);
    acc(1'b0, `MAE_EXTENDED_MODE_REG_2_OFF, `MAE_PAGE_MAP, 8'h00, q, h);
    chk("mode_rd", 22'(q), 22'h20);
    acc(1'b1, 8'(`MAE_RELOC_BASE + 1), 6'h00, 8'h5A, q, h);
    chk("reloc_hit", 22'(h), 22'h1);
    tx(mae_pkg::MAE_REQ_DATA, 16'h4001, 3'h0, {8'h5A, 14'h0001});
    acc(1'b0, `MAE_DPS1_OFF, `MAE_PAGE_MAP, 8'h00, q, h);
    chk("old_slot", {13'h0, h, q}, 22'h0);
    acc(1'b0, 8'h10, `MAE_PAGE_MAP, 8'h00, q, h);
    chk("unmapped", {13'h0, h, q}, 22'h0);
    // Save bit clear: nothing stacked, code segment kept
    core.irq_in(h, v);
    chk("no_push", 22'(h), 22'h0);
    tx(mae_pkg::MAE_REQ_FETCH, 16'h0300, 3'h0, {6'h11, 16'h0300});
    // Mid-run reset clears the code segment again
    @(posedge mclk);
    nrst <= 1'b0;
    repeat (2) @(posedge mclk);
    nrst <= 1'b1;
    repeat (3) @(posedge mclk);
    acc(1'b0, `MAE_CSS_OFF, `MAE_PAGE_MAP, 8'h00, q, h);
    chk("css_rst2", 22'(q), 22'h0);
    stop_test();
  end
endmodule
`default_nettype wire
